// File: rtl/spdc_defs.svh
// offsets, field positions, reset values and frame counts of the config block
`ifndef SPDC_DEFS_SVH
`define SPDC_DEFS_SVH

// register addresses on the serial control port (15-bit address)
`define SPDC_OFS_PRE_POST    15'h003D
`define SPDC_OFS_LOOP        15'h003E
`define SPDC_OFS_BIAS        15'h003F
`define SPDC_OFS_PREEMPH     15'h0048
`define SPDC_OFS_AUX_CTRL    15'h0057
`define SPDC_OFS_PIN_OVR     15'h0058

// reset values
`define SPDC_RST_PRE_POST    8'h00
`define SPDC_RST_LOOP        8'h20
`define SPDC_RST_BIAS        8'h4F
`define SPDC_RST_PREEMPH     8'h00
`define SPDC_RST_AUX_CTRL    8'h00
`define SPDC_RST_PIN_OVR     8'h00

// field positions
`define SPDC_POST_MSB        3
`define SPDC_POST_LSB        2
`define SPDC_PRE_MSB         1
`define SPDC_PRE_LSB         0
`define SPDC_LOOP_MSB        5
`define SPDC_BIAS_MSB        6
`define SPDC_PE_MSB          3
`define SPDC_AUX_EN_BIT      7
`define SPDC_AUX_MODE_MSB    2

// aux output mode codes
`define SPDC_AUX_UI16        3'h0
`define SPDC_AUX_UI32        3'h1
`define SPDC_AUX_UI64        3'h2
`define SPDC_AUX_TSTAMP      3'h3

// half periods of the aux clock minus one, in unit intervals
`define SPDC_HALF_UI16       5'h07
`define SPDC_HALF_UI32       5'h0F
`define SPDC_HALF_UI64       5'h1F

// serial frame: 1 direction bit, 15 address bits, 8 data bits
`define SPDC_LAST_ADDR_BIT   5'h0F
`define SPDC_LAST_FRAME_BIT  5'h17
`define SPDC_LANES           8

`endif

// File: rtl/spdc_pkg.sv
// types shared by the sampling synthesizer config block
package spdc_pkg;
    typedef logic [7:0]  spdc_byte_t;   // one register byte
    typedef logic [14:0] spdc_addr_t;   // serial port address
    typedef logic [3:0]  spdc_pe_t;     // per-lane pre-emphasis
endpackage

// File: rtl/spdc_top.sv
// sampling synthesizer divider, pre-emphasis and aux output config block
`timescale 1ns/10ps
`include "spdc_defs.svh"
module spdc_top
    import spdc_pkg::*;
(
    input  wire logic        REF_CLK_I,        // 25 MHz control clock
    input  wire logic        RSTN_I,           // synchronous reset
    input  wire logic        SPI_CS_N_I,       // serial port select
    input  wire logic        SPI_SCLK_I,       // serial port clock
    input  wire logic        SPI_SDI_I,        // serial data in
    output logic             SPI_SDO_O,        // serial data out
    input  wire logic        VCO_TICK_I,       // one pulse per vco cycle
    input  wire logic        SYNTH_RESET_I,    // synthesizer reset control
    input  wire logic        SER_UI_TICK_I,    // one pulse per lane UI
    input  wire logic        SER_REINIT_I,     // serializer reinitialising
    input  wire logic        TIMESTAMP_I,      // timestamp input level
    output logic             SAMPLE_TICK_O,    // sampling clock tick
    output logic             FEEDBACK_TICK_O,  // pfd feedback tick
    output logic [2:0]       PRESCALE_RATIO_O, // decoded prescale ratio
    output logic [2:0]       POST_RATIO_O,     // decoded post ratio
    output logic [5:0]       LOOP_RATIO_O,     // loop divide ratio
    output logic [6:0]       OSC_BIAS_LEVEL_O, // oscillator bias level
    output logic [31:0]      LANE_PREEMPH_O,   // 4 bits per lane
    output logic             SYNTH_CFG_BAD_O,  // reserved divider code
    output logic             AUX_ENABLE_O,     // aux buffer enabled
    output logic             AUX_OUT_P_O,      // aux output pair, true
    output logic             AUX_OUT_N_O       // aux output pair, comp
);

    // register storage, full bytes so reserved bits read back too
    spdc_byte_t pre_post_ff;           // prescale and post select
    spdc_byte_t loop_ff;               // loop divider
    spdc_byte_t bias_ff;               // oscillator bias
    spdc_byte_t preemph_ff;            // lane pre-emphasis
    spdc_byte_t aux_ctrl_ff;           // aux enable and mode
    spdc_byte_t pin_ovr_ff;            // pin override, stored only

    // serial port state
    logic       sclk_q_ff;             // last sampled serial clock
    logic [4:0] bit_cnt_ff;            // bits taken in this frame
    logic [23:0] shift_ff;             // incoming frame bits
    spdc_byte_t rd_shift_ff;           // outgoing read data
    logic       sdo_ff;                // serial data out
    logic       sclk_rise;             // rising serial edge
    logic       sclk_fall;             // falling serial edge
    logic       frame_wr;              // last bit of a write frame
    spdc_addr_t frame_addr;            // address of completed write
    spdc_byte_t frame_data;            // data of completed write
    spdc_addr_t rd_addr;               // address once 16 bits are in
    logic       rd_load;               // read frame reached data phase

    // synthesizer divider chain
    logic [2:0] pre_ratio_ff;          // 5, 4 or 3; 0 for reserved code
    logic [2:0] post_ratio_ff;         // 1, 2 or 4; 0 for reserved code
    logic [5:0] loop_ratio_ff;         // literal loop ratio
    logic [6:0] bias_lvl_ff;           // bias out
    logic       cfg_bad_ff;            // reserved or zero code
    logic [2:0] pre_cnt_ff;            // prescaler count
    logic [1:0] post_cnt_ff;           // post divider count
    logic [5:0] loop_cnt_ff;           // loop divider count
    logic       pre_tick_ff;           // prescaler output tick
    logic       sample_tick_ff;        // post divider output tick
    logic       fb_tick_ff;            // loop divider output tick
    logic       div_hold;              // dividers held idle

    // aux output
    spdc_pe_t   lane_pe_ff [`SPDC_LANES]; // per-lane copies
    logic [4:0] aux_cnt_ff;            // UI count in half period
    logic [4:0] aux_half;              // last count of the half period for the mode
    logic       aux_clk_ff;            // divided serializer clock
    logic       ts_ff;                 // resampled timestamp
    logic       aux_en_ff;             // enable as driven out
    logic       aux_p_ff;              // pair true side
    logic       aux_n_ff;              // pair complement side
    logic       nxt_aux_p;             // next true side level
    logic [2:0] aux_mode;              // mode field
    logic       aux_on;                // enable field

    // register read multiplexer, unmapped addresses read zero
    function automatic spdc_byte_t read_mux(input spdc_addr_t a);
        spdc_byte_t r;
        r = 8'h00;
        case (a)
            `SPDC_OFS_PRE_POST: r = pre_post_ff;
            `SPDC_OFS_LOOP:     r = loop_ff;
            `SPDC_OFS_BIAS:     r = bias_ff;
            `SPDC_OFS_PREEMPH:  r = preemph_ff;
            `SPDC_OFS_AUX_CTRL: r = aux_ctrl_ff;
            `SPDC_OFS_PIN_OVR:  r = pin_ovr_ff;
            default:            r = 8'h00;
        endcase
        return r;
    endfunction

    // serial edges; pins are synchronous to the control clock
    assign sclk_rise  = SPI_SCLK_I & ~sclk_q_ff & ~SPI_CS_N_I;
    assign sclk_fall  = ~SPI_SCLK_I & sclk_q_ff & ~SPI_CS_N_I;
    // frame layout once complete: [23] read, [22:8] addr, [7:0] data
    assign frame_wr   = sclk_rise & (bit_cnt_ff == `SPDC_LAST_FRAME_BIT)
                        & ~shift_ff[22];
    assign frame_addr = shift_ff[21:7];
    assign frame_data = {shift_ff[6:0], SPI_SDI_I};
    assign rd_addr    = {shift_ff[13:0], SPI_SDI_I};
    assign rd_load    = sclk_rise & (bit_cnt_ff == `SPDC_LAST_ADDR_BIT)
                        & shift_ff[14];

    // serial clock history
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            sclk_q_ff <= 1'b1;  // idle level, no false rise after reset
        end else begin
            sclk_q_ff <= SPI_SCLK_I;
        end
    end

    // frame shifter; deselect aborts a partial frame without writing
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I || SPI_CS_N_I) begin
            bit_cnt_ff <= 5'h00;
            shift_ff   <= 24'h000000;
        end else if (sclk_rise) begin
            shift_ff   <= {shift_ff[22:0], SPI_SDI_I};
            bit_cnt_ff <= (bit_cnt_ff == `SPDC_LAST_FRAME_BIT) ?
                          5'h00 : bit_cnt_ff + 5'h01;
        end
    end

    // read data: loaded after the address, shifted out on falling edges
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            rd_shift_ff <= 8'h00;
            sdo_ff      <= 1'b0;
        end else if (rd_load) begin
            rd_shift_ff <= read_mux(rd_addr);
        end else if (sclk_fall) begin
            sdo_ff      <= rd_shift_ff[7];
            rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
        end
    end

    // register file; whole byte kept, software owns reserved bits
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            pre_post_ff <= `SPDC_RST_PRE_POST;
            loop_ff     <= `SPDC_RST_LOOP;
            bias_ff     <= `SPDC_RST_BIAS;
            preemph_ff  <= `SPDC_RST_PREEMPH;
            aux_ctrl_ff <= `SPDC_RST_AUX_CTRL;
            pin_ovr_ff  <= `SPDC_RST_PIN_OVR;
        end else if (frame_wr) begin
            case (frame_addr)
                `SPDC_OFS_PRE_POST: pre_post_ff <= frame_data;
                `SPDC_OFS_LOOP:     loop_ff     <= frame_data;
                `SPDC_OFS_BIAS:     bias_ff     <= frame_data;
                `SPDC_OFS_PREEMPH:  preemph_ff  <= frame_data;
                `SPDC_OFS_AUX_CTRL: aux_ctrl_ff <= frame_data;
                `SPDC_OFS_PIN_OVR:  pin_ovr_ff  <= frame_data;
                default:            ;  // unmapped writes dropped
            endcase
        end
    end

    // divider decode; reserved codes and ratio zero stop the chain
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            pre_ratio_ff  <= 3'h5;
            post_ratio_ff <= 3'h1;
            loop_ratio_ff <= 6'h20;
            bias_lvl_ff   <= 7'h4F;
            cfg_bad_ff    <= 1'b0;
        end else begin
            case (pre_post_ff[`SPDC_POST_MSB:`SPDC_POST_LSB])
                2'h0:    post_ratio_ff <= 3'h1;
                2'h1:    post_ratio_ff <= 3'h2;
                2'h2:    post_ratio_ff <= 3'h4;
                default: post_ratio_ff <= 3'h0;  // reserved
            endcase
            case (pre_post_ff[`SPDC_PRE_MSB:`SPDC_PRE_LSB])
                2'h0:    pre_ratio_ff <= 3'h5;
                2'h1:    pre_ratio_ff <= 3'h4;
                2'h2:    pre_ratio_ff <= 3'h3;
                default: pre_ratio_ff <= 3'h0;   // reserved
            endcase
            loop_ratio_ff <= loop_ff[`SPDC_LOOP_MSB:0];
            bias_lvl_ff   <= bias_ff[`SPDC_BIAS_MSB:0];
            cfg_bad_ff    <= (pre_post_ff[3:2] == 2'h3)
                             | (pre_post_ff[1:0] == 2'h3)
                             | (loop_ff[`SPDC_LOOP_MSB:0] == 6'h00);
        end
    end

    // dividers only run with a legal setup and the synthesizer out of
    // reset, so a divider change under reset never glitches a count
    assign div_hold = SYNTH_RESET_I | cfg_bad_ff;

    // prescaler: vco ticks to prescaled ticks
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I || div_hold) begin
            pre_cnt_ff  <= 3'h0;
            pre_tick_ff <= 1'b0;
        end else begin
            pre_tick_ff <= 1'b0;
            if (VCO_TICK_I) begin
                if (pre_cnt_ff == pre_ratio_ff - 3'h1) begin
                    pre_cnt_ff  <= 3'h0;
                    pre_tick_ff <= 1'b1;
                end else begin
                    pre_cnt_ff  <= pre_cnt_ff + 3'h1;
                end
            end
        end
    end

    // post divider: prescaler output becomes the sampling clock
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I || div_hold) begin
            post_cnt_ff    <= 2'h0;
            sample_tick_ff <= 1'b0;
        end else begin
            sample_tick_ff <= 1'b0;
            if (pre_tick_ff) begin
                if ({1'b0, post_cnt_ff} == post_ratio_ff - 3'h1) begin
                    post_cnt_ff    <= 2'h0;
                    sample_tick_ff <= 1'b1;
                end else begin
                    post_cnt_ff    <= post_cnt_ff + 2'h1;
                end
            end
        end
    end

    // loop divider: sampling clock down to the pfd feedback clock
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I || div_hold) begin
            loop_cnt_ff <= 6'h00;
            fb_tick_ff  <= 1'b0;
        end else begin
            fb_tick_ff <= 1'b0;
            if (sample_tick_ff) begin
                if (loop_cnt_ff == loop_ratio_ff - 6'h01) begin
                    loop_cnt_ff <= 6'h00;
                    fb_tick_ff  <= 1'b1;
                end else begin
                    loop_cnt_ff <= loop_cnt_ff + 6'h01;
                end
            end
        end
    end

    // one pre-emphasis field fanned out to every lane
    genvar g;
    generate
        for (g = 0; g < `SPDC_LANES; g++) begin : g_lane
            always_ff @(posedge REF_CLK_I) begin
                if (!RSTN_I) begin
                    lane_pe_ff[g] <= 4'h0;
                end else begin
                    lane_pe_ff[g] <= preemph_ff[`SPDC_PE_MSB:0];
                end
            end
            assign LANE_PREEMPH_O[g*4 +: 4] = lane_pe_ff[g];
        end
    endgenerate

    // aux mode and half period; mode is only meant to move while off
    assign aux_mode = aux_ctrl_ff[`SPDC_AUX_MODE_MSB:0];
    assign aux_on   = aux_ctrl_ff[`SPDC_AUX_EN_BIT];
    always_comb begin
        case (aux_mode)
            `SPDC_AUX_UI16: aux_half = `SPDC_HALF_UI16;
            `SPDC_AUX_UI32: aux_half = `SPDC_HALF_UI32;
            default:        aux_half = `SPDC_HALF_UI64;
        endcase
    end

    // serializer-derived divider; restarts after each reinit
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I || !aux_on || SER_REINIT_I
            || aux_mode > `SPDC_AUX_UI64) begin
            aux_cnt_ff <= 5'h00;
            aux_clk_ff <= 1'b0;
        end else if (SER_UI_TICK_I) begin
            if (aux_cnt_ff >= aux_half) begin
                aux_cnt_ff <= 5'h00;
                aux_clk_ff <= ~aux_clk_ff;
            end else begin
                aux_cnt_ff <= aux_cnt_ff + 5'h01;
            end
        end
    end

    // output select: clock modes, timestamp, reserved parks low
    always_comb begin
        if (aux_mode == `SPDC_AUX_TSTAMP) begin
            nxt_aux_p = ts_ff;
        end else if (aux_mode <= `SPDC_AUX_UI64) begin
            nxt_aux_p = aux_clk_ff & ~SER_REINIT_I;
        end else begin
            nxt_aux_p = 1'b0;
        end
    end

    // aux buffer: both sides low while disabled
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            ts_ff     <= 1'b0;
            aux_en_ff <= 1'b0;
            aux_p_ff  <= 1'b0;
            aux_n_ff  <= 1'b0;
        end else begin
            ts_ff     <= TIMESTAMP_I;
            aux_en_ff <= aux_on;
            aux_p_ff  <= aux_on & nxt_aux_p;
            aux_n_ff  <= aux_on & ~nxt_aux_p;
        end
    end

    assign SPI_SDO_O        = sdo_ff;
    assign SAMPLE_TICK_O    = sample_tick_ff;
    assign FEEDBACK_TICK_O  = fb_tick_ff;
    assign PRESCALE_RATIO_O = pre_ratio_ff;
    assign POST_RATIO_O     = post_ratio_ff;
    assign LOOP_RATIO_O     = loop_ratio_ff;
    assign OSC_BIAS_LEVEL_O = bias_lvl_ff;
    assign SYNTH_CFG_BAD_O  = cfg_bad_ff;
    assign AUX_ENABLE_O     = aux_en_ff;
    assign AUX_OUT_P_O      = aux_p_ff;
    assign AUX_OUT_N_O      = aux_n_ff;

    // checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);

    chk_post_decode: assert property (
        pre_post_ff[3:2] == 2'h2 |=> POST_RATIO_O == 3'h4)
        else $error("post divider code 2 not decoded to 4");
    chk_pre_decode: assert property (
        pre_post_ff[1:0] == 2'h0 |=> PRESCALE_RATIO_O == 3'h5)
        else $error("prescale code 0 not decoded to 5");
    chk_chain_order: assert property (
        SAMPLE_TICK_O |-> $past(pre_tick_ff))
        else $error("sample tick without prescaler tick");
    chk_loop_literal: assert property (
        ##1 LOOP_RATIO_O == $past(loop_ff[5:0]))
        else $error("loop ratio differs from field");
    chk_feedback_src: assert property (
        FEEDBACK_TICK_O |-> $past(SAMPLE_TICK_O) && !SAMPLE_TICK_O)
        else $error("feedback tick not from sample tick");
    chk_lanes_equal: assert property (
        ##1 lane_pe_ff[0] == $past(preemph_ff[3:0])
        && lane_pe_ff[7] == lane_pe_ff[0])
        else $error("lane pre-emphasis not global");
    chk_aux_disabled: assert property (
        !aux_on |=> !AUX_OUT_P_O && !AUX_OUT_N_O && !AUX_ENABLE_O)
        else $error("aux output active while disabled");
    chk_aux_tstamp: assert property (
        aux_on && aux_mode == 3'h3 |=> AUX_OUT_P_O == $past(TIMESTAMP_I, 2))
        else $error("aux output not the resampled timestamp");
    chk_reinit_blank: assert property (
        SER_REINIT_I && aux_mode <= 3'h2 |=> !AUX_OUT_P_O ##1 !AUX_OUT_P_O)
        else $error("aux clock alive during serializer reinit");
    chk_write_back: assert property (
        frame_wr && frame_addr == 15'h003F |=> bias_ff == $past(frame_data))
        else $error("bias register did not take written value");

    cov_write: cover property (frame_wr);
    cov_read: cover property (rd_load);
    cov_feedback: cover property (FEEDBACK_TICK_O);
    cov_aux_toggle: cover property (aux_on && $rose(AUX_OUT_P_O));

endmodule

// File: testbench/tb_spdc_top.sv
// self-checking testbench for the synthesizer config block
`timescale 1ns/10ps
`include "spdc_defs.svh"
module tb_spdc_top
    import spdc_pkg::*;
;
    logic        clk;      // 25 MHz control clock
    logic        rstn;     // synchronous reset, active low
    logic        cs_n;     // serial select
    logic        sclk;     // serial clock level
    logic        sdi;      // serial data to block
    logic        sdo;      // serial data from block
    logic        vco;      // vco tick
    logic        srst;     // synthesizer reset control
    logic        uit;      // lane UI tick
    logic        reinit;   // serializer reinit
    logic        tstamp;   // timestamp level
    logic        smp;      // sample tick
    logic        fbk;      // feedback tick
    logic [2:0]  pre_r;    // prescale ratio
    logic [2:0]  post_r;   // post ratio
    logic [5:0]  loop_r;   // loop ratio
    logic [6:0]  bias;     // bias level
    logic [31:0] pe;       // lane pre-emphasis
    logic        bad;      // reserved divider config
    logic        aux_en;   // aux enable
    logic        aux_p;    // aux true
    logic        aux_n;    // aux complement
    int          err_count;
    int          compares;
    spdc_byte_t  q;        // last read byte

    spdc_top i_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .SPI_CS_N_I(cs_n),
        .SPI_SCLK_I(sclk), .SPI_SDI_I(sdi), .SPI_SDO_O(sdo),
        .VCO_TICK_I(vco), .SYNTH_RESET_I(srst), .SER_UI_TICK_I(uit),
        .SER_REINIT_I(reinit), .TIMESTAMP_I(tstamp),
        .SAMPLE_TICK_O(smp), .FEEDBACK_TICK_O(fbk),
        .PRESCALE_RATIO_O(pre_r), .POST_RATIO_O(post_r),
        .LOOP_RATIO_O(loop_r), .OSC_BIAS_LEVEL_O(bias),
        .LANE_PREEMPH_O(pe), .SYNTH_CFG_BAD_O(bad),
        .AUX_ENABLE_O(aux_en), .AUX_OUT_P_O(aux_p), .AUX_OUT_N_O(aux_n));

    // free-running clock
    always #20 clk = ~clk;

    // one compare, counted
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // one 24-bit frame; sclk levels held 3+ cycles, sdo taken before rise
    task automatic frame(input logic rd, input spdc_addr_t a,
                         input spdc_byte_t d);
        logic [23:0] f;
        f = {rd, a, d};
        cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk);
            sclk <= 1'b0;
            sdi  <= f[i];
            repeat (4) @(posedge clk);
            if (i < 8) q[i] = sdo;
            sclk <= 1'b1;
            repeat (2) @(posedge clk);
        end
        @(posedge clk);
        cs_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // write then read back the same register
    task automatic wr_rd(input spdc_addr_t a, input spdc_byte_t d);
        frame(1'b0, a, d);
        frame(1'b1, a, 8'h00);
        chk("readback", {24'h0, d}, {24'h0, q});
    endtask

    // vco ticks every cycle for n cycles, then count the outputs
    task automatic run_vco(input int n, input int es, input int ef);
        int s;
        int fb;
        s = 0;
        fb = 0;
        for (int i = 0; i < n + 8; i++) begin
            @(posedge clk);
            s += smp;
            fb += fbk;
            vco <= (i < n);
        end
        chk("sample ticks", es, s);
        chk("feedback ticks", ef, fb);
    endtask

    // reset values of every register and the decoded outputs
    task automatic t_reset();
        spdc_addr_t ofs [6] = '{`SPDC_OFS_PRE_POST, `SPDC_OFS_LOOP,
            `SPDC_OFS_BIAS, `SPDC_OFS_PREEMPH, `SPDC_OFS_AUX_CTRL,
            `SPDC_OFS_PIN_OVR};
        spdc_byte_t rv [6] = '{8'h00, 8'h20, 8'h4F, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 6; k++) begin
            frame(1'b1, ofs[k], 8'h00);
            chk("reset value", {24'h0, rv[k]}, {24'h0, q});
        end
        chk("prescale", 32'h5, {29'h0, pre_r});
        chk("post", 32'h1, {29'h0, post_r});
        chk("loop", 32'h20, {26'h0, loop_r});
        chk("bias", 32'h4F, {25'h0, bias});
        chk("lanes", 32'h0, pe);
        chk("aux enable", 32'h0, {31'h0, aux_en});
        // unmapped place: write ignored, reads zero
        frame(1'b0, 15'h0040, 8'hFF);
        frame(1'b1, 15'h0040, 8'h00);
        chk("unmapped", 32'h0, {24'h0, q});
        $display("test reset values done");
    endtask

    // every divider code, loop limit, bias and lane pre-emphasis
    task automatic t_decode();
        logic [2:0] pe_exp [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
        logic [2:0] po_exp [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
        srst <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr_rd(`SPDC_OFS_PRE_POST, {4'h0, k[1:0], k[1:0]});
            chk("prescale", {29'h0, pe_exp[k]}, {29'h0, pre_r});
            chk("post", {29'h0, po_exp[k]}, {29'h0, post_r});
            chk("cfg bad", {31'h0, k == 3}, {31'h0, bad});
        end
        wr_rd(`SPDC_OFS_LOOP, 8'h3F);
        chk("loop", 32'h3F, {26'h0, loop_r});
        wr_rd(`SPDC_OFS_BIAS, 8'h4A);
        chk("bias", 32'h4A, {25'h0, bias});
        wr_rd(`SPDC_OFS_PREEMPH, 8'h0B);
        chk("lanes", 32'hBBBBBBBB, pe);
        wr_rd(`SPDC_OFS_PIN_OVR, 8'hA5);
        srst <= 1'b0;
        $display("test decode done");
    endtask

    // divide by 3 then 2, loop 2; held reset and reserved code stop it
    task automatic t_chain();
        srst <= 1'b1;
        frame(1'b0, `SPDC_OFS_PRE_POST, 8'h06);
        frame(1'b0, `SPDC_OFS_LOOP, 8'h02);
        run_vco(60, 0, 0);
        srst <= 1'b0;
        run_vco(60, 10, 5);
        srst <= 1'b1;
        frame(1'b0, `SPDC_OFS_PRE_POST, 8'h03);
        srst <= 1'b0;
        run_vco(30, 0, 0);
        $display("test divider chain done");
    endtask

    // aux clock modes, reinit drop-out, timestamp, disable
    task automatic t_aux();
        int tg;
        logic prv;
        for (int m = 0; m < 3; m++) begin
            frame(1'b0, `SPDC_OFS_AUX_CTRL, {5'h0, m[2:0]});
            frame(1'b0, `SPDC_OFS_AUX_CTRL, {5'h10, m[2:0]});
            chk("aux enable", 32'h1, {31'h0, aux_en});
            tg = 0;
            prv = aux_p;
            for (int i = 0; i < 68; i++) begin
                @(posedge clk);
                tg += (aux_p !== prv);
                prv = aux_p;
                chk("aux pair", {31'h0, ~aux_p}, {31'h0, aux_n});
                uit <= (i < 64);
            end
            chk("aux toggles", 8 >> m, tg);
        end
        // 32 more UI ticks raise the mode 2 clock, so reinit must drop it
        @(posedge clk);
        uit <= 1'b1;
        repeat (32) @(posedge clk);
        uit <= 1'b0;
        repeat (3) @(posedge clk);
        chk("aux high", 32'h1, {31'h0, aux_p});
        reinit <= 1'b1;
        repeat (3) @(posedge clk);
        chk("aux reinit", 32'h0, {31'h0, aux_p});
        reinit <= 1'b0;
        frame(1'b0, `SPDC_OFS_AUX_CTRL, 8'h03);
        frame(1'b0, `SPDC_OFS_AUX_CTRL, 8'h83);
        tstamp <= 1'b1;
        repeat (4) @(posedge clk);
        chk("aux stamp", 32'h1, {31'h0, aux_p});
        chk("aux stamp n", 32'h0, {31'h0, aux_n});
        frame(1'b0, `SPDC_OFS_AUX_CTRL, 8'h03);
        chk("aux off p", 32'h0, {31'h0, aux_p});
        chk("aux off n", 32'h0, {31'h0, aux_n});
        // reserved mode parks the true side low while enabled
        frame(1'b0, `SPDC_OFS_AUX_CTRL, 8'h04);
        frame(1'b0, `SPDC_OFS_AUX_CTRL, 8'h84);
        chk("aux reserved p", 32'h0, {31'h0, aux_p});
        chk("aux reserved n", 32'h1, {31'h0, aux_n});
        frame(1'b0, `SPDC_OFS_AUX_CTRL, 8'h04);
        chk("aux reserved off", 32'h0, {31'h0, aux_n});
        tstamp <= 1'b0;
        $display("test aux output done");
    endtask

    // single place where the run ends
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard, well beyond the ~7k cycles the tests take
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    // main sequence
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        cs_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
        vco = 1'b0;
        srst = 1'b0;
        uit = 1'b0;
        reinit = 1'b0;
        tstamp = 1'b0;
        err_count = 0;
        compares = 0;
        q = 8'h00;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_decode();
        t_chain();
        t_aux();
        print_verdict();
    end
endmodule
